// ==== fcd_pkg.sv ====
// Behaviour
// - sign bit 0 positive, 1 negative
// - significand is integer bit plus fraction
// - single format is 32 bits wide
// - single normal biased exponent 1 to 254
// - both zero signs compare equal
// - zero sign from operation and rounding
// - zero exponent nonzero is denormal, J=0
// - normalize: shift left, decrement exponent
// - normalize whenever exponent range allows
// - too small: shift right to minimum exponent
// - all bits shifted out gives zero
// - denormal result raises underflow
// - denormal source raises denormal operand
// - masked denormal normalized into extended
// - conditional move only when condition true
// - compare writes integer flags register
// - infinity: zero significand, maximum exponent
// - maximum exponent, nonzero fraction is NaN
// - fraction msb set quiet, clear signaling
package fcd_pkg;
   // ***********************
   // formats
   // ***********************
   localparam int OPND_W   = 64;
   localparam int SIG_W    = 64;
   localparam int RES_W    = 80;
   localparam int S_EXP_W  = 8;
   localparam int S_FRAC_W = 23;
   localparam int S_SIGN_P = 31;
   localparam int S_BIAS   = 127;
   localparam int S_EMIN   = -126;
   localparam int D_EXP_W  = 11;
   localparam int D_FRAC_W = 52;
   localparam int D_SIGN_P = 63;
   localparam int D_BIAS   = 1023;
   localparam int X_EXP_W  = 15;
   localparam int X_BIAS   = 16383;
   localparam int TR_EXP_W = 16;
   localparam logic [S_EXP_W-1:0] S_EXP_MAX = 8'hff;
   localparam logic [D_EXP_W-1:0] D_EXP_MAX = 11'h7ff;
   localparam logic [X_EXP_W-1:0] X_EXP_MAX = 15'h7fff;
   // ***********************
   // types
   // ***********************
   typedef enum logic [2:0] {
      OP_CLASSIFY = 3'h0,
      OP_TO_EXT   = 3'h1,
      OP_PACK_SGL = 3'h2,
      OP_CMOV     = 3'h3,
      OP_CMP      = 3'h4,
      OP_CMP_POP  = 3'h5,
      OP_UCMP_POP = 3'h6
   } fcd_op_type;
   typedef enum logic {FMT_SGL = 1'h0, FMT_DBL = 1'h1} fcd_fmt_type;
   typedef enum logic [2:0] {
      CLS_ZERO = 3'h0,
      CLS_DEN  = 3'h1,
      CLS_NORM = 3'h2,
      CLS_INF  = 3'h3,
      CLS_QNAN = 3'h4,
      CLS_SNAN = 3'h5
   } fcd_cls_type;
   typedef enum logic [1:0] {
      RC_NEAR = 2'h0,
      RC_DOWN = 2'h1,
      RC_UP   = 2'h2,
      RC_ZERO = 2'h3
   } fcd_rc_type;
   typedef enum logic [1:0] {
      CC_B  = 2'h0,
      CC_E  = 2'h1,
      CC_BE = 2'h2,
      CC_U  = 2'h3
   } fcd_cc_type;
   typedef struct packed {
      logic zf;
      logic pf;
      logic cf;
   } fcd_flags_type;
   localparam fcd_flags_type FL_GT    = 3'h0;
   localparam fcd_flags_type FL_LT    = 3'h1;
   localparam fcd_flags_type FL_EQ    = 3'h4;
   localparam fcd_flags_type FL_UNORD = 3'h7;
   typedef struct packed {
      logic                sign;
      logic [D_EXP_W-1:0]  exp;
      logic [D_FRAC_W-1:0] frac;
   } fcd_fld_type;
   typedef struct packed {
      fcd_op_type                  op;
      fcd_fmt_type                 fmt;
      logic [OPND_W-1:0]           a;
      logic [OPND_W-1:0]           b;
      logic                        cc_neg;
      fcd_cc_type                  cc;
      logic                        den_mask;
      fcd_rc_type                  rc;
      fcd_flags_type               flags;
      logic                        tr_sign;
      logic signed [TR_EXP_W-1:0]  tr_exp;
      logic [SIG_W-1:0]            tr_sig;
      logic                        tr_cancel;
   } fcd_req_type;
   typedef struct packed {
      logic underflow;
      logic denormal;
      logic invalid;
   } fcd_evt_type;
   typedef struct packed {
      logic [RES_W-1:0] result;
      logic             wr;
      fcd_cls_type      cls;
      fcd_flags_type    flags;
      logic             pop;
      fcd_evt_type      evt;
   } fcd_rsp_type;
endpackage

// ==== fcd_core.sv ====
`timescale 1ns/1ps
module fcd_core (
   input  wire logic                 clk_sys_i,
   input  wire logic                 rst_i,
   input  wire logic                 ce_i,
   input  wire logic                 req_valid_i,
   input  wire fcd_pkg::fcd_req_type req_i,
   output logic                      rsp_valid_o,
   output fcd_pkg::fcd_rsp_type      rsp_o
);
   localparam int SW = fcd_pkg::SIG_W;
   localparam int DF = fcd_pkg::D_FRAC_W;
   localparam int SF = fcd_pkg::S_FRAC_W;
   localparam int SE = fcd_pkg::S_EXP_W;
   localparam int PADW = SW - 1 - DF;

   // ***********************
   // decoding helpers
   // ***********************
   function automatic fcd_pkg::fcd_fld_type split(
      input logic [fcd_pkg::OPND_W-1:0] raw,
      input fcd_pkg::fcd_fmt_type       f);
      fcd_pkg::fcd_fld_type r;
      if (f == fcd_pkg::FMT_SGL) begin
         r.sign = raw[fcd_pkg::S_SIGN_P];
         r.exp  = fcd_pkg::D_EXP_W'(raw[fcd_pkg::S_SIGN_P-1 -: SE]);
         // left-align so the quiet bit sits at the top for both formats
         r.frac = DF'(raw[SF-1:0]) << (DF - SF);
      end else begin
         r.sign = raw[fcd_pkg::D_SIGN_P];
         r.exp  = raw[fcd_pkg::D_SIGN_P-1 -: fcd_pkg::D_EXP_W];
         r.frac = raw[DF-1:0];
      end
      return r;
   endfunction

   function automatic fcd_pkg::fcd_cls_type classify(
      input fcd_pkg::fcd_fld_type fl,
      input fcd_pkg::fcd_fmt_type f);
      logic [fcd_pkg::D_EXP_W-1:0] emax;
      emax = (f == fcd_pkg::FMT_SGL) ?
             fcd_pkg::D_EXP_W'(fcd_pkg::S_EXP_MAX) : fcd_pkg::D_EXP_MAX;
      if (fl.exp == '0) begin
         classify = (fl.frac == '0) ? fcd_pkg::CLS_ZERO
                                    : fcd_pkg::CLS_DEN;
      end else if (fl.exp == emax) begin
         if (fl.frac == '0) begin
            classify = fcd_pkg::CLS_INF;
         end else begin
            classify = fl.frac[DF-1] ? fcd_pkg::CLS_QNAN
                                     : fcd_pkg::CLS_SNAN;
         end
      end else begin
         classify = fcd_pkg::CLS_NORM;
      end
   endfunction

   function automatic logic [6:0] lzc(input logic [SW-1:0] s);
      logic [6:0] n;
      n = 7'(SW);
      for (int i = 0; i < SW; i++) begin
         if (s[i]) begin
            n = 7'(SW - 1 - i);
         end
      end
      return n;
   endfunction

   function automatic logic is_nan(input fcd_pkg::fcd_cls_type c);
      return (c == fcd_pkg::CLS_QNAN) || (c == fcd_pkg::CLS_SNAN);
   endfunction

   // ***********************
   // operand decode
   // ***********************
   fcd_pkg::fcd_fld_type fa;
   fcd_pkg::fcd_fld_type fb;
   fcd_pkg::fcd_cls_type ca;
   fcd_pkg::fcd_cls_type cb;
   logic                 go;

   assign fa = split(req_i.a, req_i.fmt);
   assign fb = split(req_i.b, req_i.fmt);
   assign ca = classify(fa, req_i.fmt);
   assign cb = classify(fb, req_i.fmt);
   assign go = ce_i && req_valid_i;

   // ***********************
   // conversion to extended
   // ***********************
   logic [SW-1:0]               cv_sig;
   int                          cv_exp;
   int                          cv_bias;
   logic                        cv_ok;
   logic [fcd_pkg::RES_W-1:0]   cv_res;

   always_comb begin
      cv_bias = (req_i.fmt == fcd_pkg::FMT_SGL) ? fcd_pkg::S_BIAS
                                                : fcd_pkg::D_BIAS;
      cv_ok   = 1'b1;
      // explicit integer bit restored for normal values
      cv_sig  = {1'b1, fa.frac, PADW'(0)};
      cv_exp  = int'(fa.exp) - cv_bias + fcd_pkg::X_BIAS;
      case (ca)
         fcd_pkg::CLS_ZERO: begin
            cv_sig = '0;
            cv_exp = 0;
         end
         fcd_pkg::CLS_DEN: begin
            cv_sig = {1'b0, fa.frac, PADW'(0)};
            cv_exp = 1 - cv_bias + fcd_pkg::X_BIAS - int'(lzc(cv_sig));
            cv_sig = cv_sig << lzc(cv_sig);
            // unmasked: no result, software handles the fault
            cv_ok  = req_i.den_mask;
         end
         fcd_pkg::CLS_INF: begin
            cv_sig = '0;
            cv_exp = int'(fcd_pkg::X_EXP_MAX);
         end
         fcd_pkg::CLS_QNAN, fcd_pkg::CLS_SNAN: begin
            cv_exp = int'(fcd_pkg::X_EXP_MAX);
         end
         default: begin
         end
      endcase
      cv_res = {fa.sign, cv_exp[fcd_pkg::X_EXP_W-1:0], cv_sig};
   end

   // ***********************
   // single result packing
   // ***********************
   int               pk_lz;
   int               pk_sh;
   int               pk_e;
   int               pk_bexp;
   logic [SW-1:0]    pk_sig;
   logic             pk_sign;
   logic [SE-1:0]    pk_ef;
   logic             pk_under;
   logic [fcd_pkg::RES_W-1:0] pk_res;

   always_comb begin
      pk_lz = int'(lzc(req_i.tr_sig));
      pk_sh = 0;
      pk_e  = int'(req_i.tr_exp);
      if (pk_e < fcd_pkg::S_EMIN) begin
         pk_sh  = fcd_pkg::S_EMIN - pk_e;
         // leading zeros move in until minimum exponent is reached
         pk_sig = (pk_sh >= SW) ? '0 : req_i.tr_sig >> pk_sh;
         pk_e   = fcd_pkg::S_EMIN;
      end else begin
         // normalize only as far as the exponent range allows
         pk_sh  = (pk_lz < pk_e - fcd_pkg::S_EMIN) ? pk_lz
                                                   : pk_e - fcd_pkg::S_EMIN;
         pk_sig = req_i.tr_sig << pk_sh;
         pk_e   = pk_e - pk_sh;
      end
      pk_bexp  = pk_e + fcd_pkg::S_BIAS;
      pk_sign  = req_i.tr_sign;
      pk_under = 1'b0;
      pk_ef    = pk_bexp[SE-1:0];
      // bits below the kept fraction are truncated, so they count as lost
      if (pk_sig[SW-1 -: SF+1] == '0) begin
         pk_ef = '0;
         if (req_i.tr_sig == '0 && req_i.tr_cancel) begin
            // exact cancellation: only round-down yields -0
            pk_sign = (req_i.rc == fcd_pkg::RC_DOWN);
         end
      end else if (!pk_sig[SW-1]) begin
         pk_ef    = '0;
         pk_under = 1'b1;
      end else if (pk_bexp >= int'(fcd_pkg::S_EXP_MAX)) begin
         // overflow saturates to infinity; rounding is out of scope
         pk_ef  = fcd_pkg::S_EXP_MAX;
         pk_sig = '0;
      end
      pk_res = fcd_pkg::RES_W'({pk_sign, pk_ef,
                                pk_sig[SW-2 -: SF]});
   end

   // ***********************
   // compare and move
   // ***********************
   fcd_pkg::fcd_flags_type cm_flags;
   logic                   cm_unord;
   logic                   cm_inv;
   logic                   mv_cond;
   logic                   mv_take;

   always_comb begin
      cm_unord = is_nan(ca) || is_nan(cb);
      if (cm_unord) begin
         cm_flags = fcd_pkg::FL_UNORD;
      end else if (ca == fcd_pkg::CLS_ZERO &&
                   cb == fcd_pkg::CLS_ZERO) begin
         cm_flags = fcd_pkg::FL_EQ;
      end else if (fa.sign != fb.sign) begin
         cm_flags = fa.sign ? fcd_pkg::FL_LT : fcd_pkg::FL_GT;
      end else if ({fa.exp, fa.frac} == {fb.exp, fb.frac}) begin
         cm_flags = fcd_pkg::FL_EQ;
      end else begin
         cm_flags = (({fa.exp, fa.frac} < {fb.exp, fb.frac}) ^ fa.sign)
                    ? fcd_pkg::FL_LT : fcd_pkg::FL_GT;
      end
      // unordered flavour only objects to signaling NaNs
      if (req_i.op == fcd_pkg::OP_UCMP_POP) begin
         cm_inv = (ca == fcd_pkg::CLS_SNAN) || (cb == fcd_pkg::CLS_SNAN);
      end else begin
         cm_inv = cm_unord;
      end
   end

   always_comb begin
      case (req_i.cc)
         fcd_pkg::CC_B:  mv_cond = req_i.flags.cf;
         fcd_pkg::CC_E:  mv_cond = req_i.flags.zf;
         fcd_pkg::CC_BE: mv_cond = req_i.flags.cf | req_i.flags.zf;
         fcd_pkg::CC_U:  mv_cond = req_i.flags.pf;
         default:        mv_cond = 1'b0;
      endcase
      mv_take = mv_cond ^ req_i.cc_neg;
   end

   // ***********************
   // response select
   // ***********************
   fcd_pkg::fcd_rsp_type rsp_d;
   fcd_pkg::fcd_rsp_type rsp_q;
   logic                 valid_q;

   always_comb begin
      rsp_d        = '0;
      rsp_d.cls    = ca;
      rsp_d.flags  = req_i.flags;
      case (req_i.op)
         fcd_pkg::OP_CLASSIFY: begin
            rsp_d.result = fcd_pkg::RES_W'(req_i.a);
         end
         fcd_pkg::OP_TO_EXT: begin
            rsp_d.result       = cv_res;
            rsp_d.wr           = cv_ok;
            rsp_d.evt.denormal = (ca == fcd_pkg::CLS_DEN);
         end
         fcd_pkg::OP_PACK_SGL: begin
            rsp_d.result        = pk_res;
            rsp_d.wr            = 1'b1;
            rsp_d.evt.underflow = pk_under;
         end
         fcd_pkg::OP_CMOV: begin
            rsp_d.result = fcd_pkg::RES_W'(mv_take ? req_i.b : req_i.a);
            rsp_d.wr     = mv_take;
         end
         fcd_pkg::OP_CMP, fcd_pkg::OP_CMP_POP,
         fcd_pkg::OP_UCMP_POP: begin
            rsp_d.flags        = cm_flags;
            rsp_d.pop          = (req_i.op != fcd_pkg::OP_CMP);
            rsp_d.evt.invalid  = cm_inv;
            rsp_d.evt.denormal = (ca == fcd_pkg::CLS_DEN) ||
                                 (cb == fcd_pkg::CLS_DEN);
         end
         default: begin
         end
      endcase
   end

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         valid_q <= 1'b0;
      end else if (ce_i) begin
         valid_q <= req_valid_i;
      end
   end

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         rsp_q <= '0;
      end else if (go) begin
         rsp_q <= rsp_d;
      end
   end

   assign rsp_valid_o = valid_q;
   assign rsp_o       = rsp_q;

   // ***********************
   // checks
   // ***********************
   rsp_latency_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      go |=> rsp_valid_o)
      else $error("response missing one cycle after request");
   unord_flags_a: assert property (
      @(posedge clk_sys_i) disable iff (rst_i)
      go && req_i.op == fcd_pkg::OP_CMP && req_i.fmt == fcd_pkg::FMT_SGL &&
      req_i.a[fcd_pkg::S_SIGN_P-1 -: SE] == fcd_pkg::S_EXP_MAX &&
      req_i.a[SF-1:0] != '0
      |=> rsp_o.flags == fcd_pkg::FL_UNORD && rsp_o.evt.invalid)
      else $error("nan compare not unordered");
   zero_equal_a: assert property (
      @(posedge clk_sys_i) disable iff (rst_i)
      go && req_i.op == fcd_pkg::OP_CMP && req_i.fmt == fcd_pkg::FMT_SGL &&
      req_i.a[fcd_pkg::S_SIGN_P-1:0] == '0 &&
      req_i.b[fcd_pkg::S_SIGN_P-1:0] == '0
      |=> rsp_o.flags == fcd_pkg::FL_EQ)
      else $error("signed zeros not equal");
   den_event_a: assert property (
      @(posedge clk_sys_i) disable iff (rst_i)
      go && req_i.op == fcd_pkg::OP_TO_EXT && req_i.fmt == fcd_pkg::FMT_SGL
      && req_i.a[fcd_pkg::S_SIGN_P-1 -: SE] == '0 && req_i.a[SF-1:0] != '0
      |=> rsp_o.evt.denormal && rsp_o.wr == $past(req_i.den_mask))
      else $error("denormal operand not flagged");
   den_norm_a: assert property (
      @(posedge clk_sys_i) disable iff (rst_i)
      go && req_i.op == fcd_pkg::OP_TO_EXT && req_i.den_mask &&
      req_i.fmt == fcd_pkg::FMT_SGL &&
      req_i.a[fcd_pkg::S_SIGN_P-1 -: SE] == '0 && req_i.a[SF-1:0] != '0
      |=> rsp_o.result[SW-1])
      else $error("masked denormal not normalized");
   undf_shape_a: assert property (
      @(posedge clk_sys_i) disable iff (rst_i)
      rsp_valid_o && rsp_o.evt.underflow
      |-> rsp_o.result[fcd_pkg::S_SIGN_P-1 -: SE] == '0 &&
          rsp_o.result[SF-1:0] != '0)
      else $error("underflow without denormal result");
   shift_out_a: assert property (
      @(posedge clk_sys_i) disable iff (rst_i)
      go && req_i.op == fcd_pkg::OP_PACK_SGL &&
      int'(req_i.tr_exp) < fcd_pkg::S_EMIN - SW
      |=> rsp_o.result[fcd_pkg::S_SIGN_P-1:0] == '0 &&
          !rsp_o.evt.underflow)
      else $error("fully shifted result not zero");
   zero_sign_a: assert property (
      @(posedge clk_sys_i) disable iff (rst_i)
      go && req_i.op == fcd_pkg::OP_PACK_SGL && req_i.tr_sig == '0 &&
      req_i.tr_cancel
      |=> rsp_o.result[fcd_pkg::S_SIGN_P] ==
          ($past(req_i.rc) == fcd_pkg::RC_DOWN))
      else $error("cancelled zero has wrong sign");
   cmov_take_a: assert property (
      @(posedge clk_sys_i) disable iff (rst_i)
      go && req_i.op == fcd_pkg::OP_CMOV && req_i.cc == fcd_pkg::CC_E
      |=> rsp_o.wr ==
          ($past(req_i.flags.zf) ^ $past(req_i.cc_neg)))
      else $error("conditional move ignored condition");
   norm_class_a: assert property (
      @(posedge clk_sys_i) disable iff (rst_i)
      go && req_i.op == fcd_pkg::OP_CLASSIFY &&
      req_i.fmt == fcd_pkg::FMT_SGL &&
      req_i.a[fcd_pkg::S_SIGN_P-1 -: SE] != '0 &&
      req_i.a[fcd_pkg::S_SIGN_P-1 -: SE] != fcd_pkg::S_EXP_MAX
      |=> rsp_o.cls == fcd_pkg::CLS_NORM)
      else $error("normal value misclassified");
endmodule

// ==== fcd_core_model.sv ====
`timescale 1ns/1ps
module fcd_core_model (
   input  wire logic                 clk_sys_i,
   input  wire logic                 rsp_valid_i,
   input  wire fcd_pkg::fcd_rsp_type rsp_i,
   output logic                      ce_o,
   output logic                      req_valid_o,
   output fcd_pkg::fcd_req_type      req_o
);
   initial begin
      ce_o        = 1'h1;
      req_valid_o = 1'h0;
      req_o       = '0;
   end
   // ****************
   // issue one request
   // ****************
   // random ce stalls stand in for a slow sequencer
   task automatic issue(input  fcd_pkg::fcd_req_type r,
                        output fcd_pkg::fcd_rsp_type s,
                        output logic                 v);
      @(negedge clk_sys_i);
      req_o       = r;
      req_valid_o = 1'h1;
      ce_o        = ($urandom % 4) != 0;
      while (!ce_o) begin
         @(negedge clk_sys_i);
         ce_o = ($urandom % 2) != 0;
      end
      @(negedge clk_sys_i);
      req_valid_o = 1'h0;
      ce_o        = 1'h1;
      // released fields show garbage, not the last request
      req_o       = ~r;
      s           = rsp_i;
      v           = rsp_valid_i;
   endtask
endmodule

// ==== test_float_classify_denormalize.sv ====
`timescale 1ns/1ps
module test_float_classify_denormalize;
   logic                 clk_sys_i;
   logic                 rst_i;
   logic                 ce_i;
   logic                 req_valid_i;
   logic                 rsp_valid_o;
   logic                 v;
   logic                 c;
   fcd_pkg::fcd_req_type req_i;
   fcd_pkg::fcd_req_type r;
   fcd_pkg::fcd_rsp_type rsp_o;
   fcd_pkg::fcd_rsp_type s;
   logic [31:0]          x;
   logic [31:0]          y;
   logic [32:0]          ex;
   logic [63:0]          sg;
   int                   n_fail;
   int                   check_count;
   int                   k;
   int                   e;
   logic [31:0]          tbl [11] = '{32'h0, 32'h80000000, 32'h00000001,
      32'h007fffff, 32'h00800000, 32'h7f7fffff, 32'h7f800000, 32'hff800000,
      32'h7fc00000, 32'h7f800001, 32'h43322000};
   int                   pe [8] = '{-129, -149, -200, 128, 127, -126, 10,
      -150};
   logic [63:0]          ps [8] = '{64'hae00000000000000,
      64'h8000000000000000, 64'h8000000000000000, 64'h8000000000000000,
      64'hffffffffffffffff, 64'h4000000000000000, 64'h0000010000000000,
      64'h8000000000000000};
   logic [31:0]          ca [7] = '{32'h0, 32'h3f800000, 32'hc0000000,
      32'h7f800000, 32'h7fc00000, 32'h7f800001, 32'h00000001};
   logic [31:0]          cb [7] = '{32'h80000000, 32'h40000000, 32'h3f800000,
      32'h7f7fffff, 32'h0, 32'h0, 32'h0};

   initial begin
      clk_sys_i = 1'h0;
      forever #5 clk_sys_i = ~clk_sys_i;
   end

   fcd_core DUT (
      .clk_sys_i  (clk_sys_i),
      .rst_i      (rst_i),
      .ce_i       (ce_i),
      .req_valid_i(req_valid_i),
      .req_i      (req_i),
      .rsp_valid_o(rsp_valid_o),
      .rsp_o      (rsp_o)
   );
   fcd_core_model u_core (
      .clk_sys_i  (clk_sys_i),
      .rsp_valid_i(rsp_valid_o),
      .rsp_i      (rsp_o),
      .ce_o       (ce_i),
      .req_valid_o(req_valid_i),
      .req_o      (req_i)
   );
   // ****************
   // expected values
   // ****************
   function automatic fcd_pkg::fcd_cls_type cls_f(logic [63:0] a, logic d);
      logic em, ez, fz, fm;
      em = d ? &a[62:52] : &a[30:23];
      ez = d ? ~|a[62:52] : ~|a[30:23];
      fz = d ? ~|a[51:0] : ~|a[22:0];
      fm = d ? a[51] : a[22];
      if (em)
         return fz ? fcd_pkg::CLS_INF :
                (fm ? fcd_pkg::CLS_QNAN : fcd_pkg::CLS_SNAN);
      if (!ez)
         return fcd_pkg::CLS_NORM;
      return fz ? fcd_pkg::CLS_ZERO : fcd_pkg::CLS_DEN;
   endfunction
   function automatic fcd_pkg::fcd_cls_type cl(logic [31:0] a);
      return cls_f({32'h0, a}, 1'h0);
   endfunction
   function automatic logic [79:0] to_ext(logic [31:0] a);
      logic [63:0] sv;
      int          ev, i;
      sv = {1'h1, a[22:0], 40'h0};
      ev = int'(a[30:23]) + 16256;
      if (a[30:23] == 8'hff) begin
         ev = 32'h7fff;
         if (a[22:0] == 23'h0)
            sv = 64'h0;
      end else if (a[30:23] == 8'h0) begin
         i = 22;
         while (i > 0 && !a[i])
            i--;
         sv = 64'(a[22:0]) << (63 - i);
         ev = a[22:0] == 23'h0 ? 0 : i + 16234;
      end
      return {a[31], ev[14:0], sv};
   endfunction
   // masked double denormal widened to extended
   function automatic logic [79:0] dext(logic [63:0] a);
      int i;
      i = 51;
      while (i > 0 && !a[i])
         i--;
      return {a[63], 15'(i + 15309), 64'(a[51:0]) << (63 - i)};
   endfunction
   // underflow flag on top of the packed single
   function automatic logic [32:0] pack(logic sn, int ev, logic [63:0] sv,
                                        logic cn, fcd_pkg::fcd_rc_type rc);
      if (sv == 64'h0)
         return {1'h0, cn ? rc == fcd_pkg::RC_DOWN : sn, 31'h0};
      while (!sv[63] && ev > -126) begin
         sv = sv << 1;
         ev--;
      end
      while (ev < -126 && sv != 64'h0) begin
         sv = sv >> 1;
         ev++;
      end
      if (sv[63:40] == 24'h0)
         return {1'h0, sn, 31'h0};
      if (ev + 127 >= 255)
         return {1'h0, sn, 8'hff, 23'h0};
      if (!sv[63])
         return {1'h1, sn, 8'h0, sv[62:40]};
      return {1'h0, sn, 8'(ev + 127), sv[62:40]};
   endfunction
   function automatic fcd_pkg::fcd_flags_type cmp(logic [31:0] a,
                                                  logic [31:0] b);
      int ka, kb;
      if (cl(a) >= fcd_pkg::CLS_QNAN || cl(b) >= fcd_pkg::CLS_QNAN)
         return fcd_pkg::FL_UNORD;
      ka = a[31] ? -int'(a[30:0]) : int'(a[30:0]);
      kb = b[31] ? -int'(b[30:0]) : int'(b[30:0]);
      return ka == kb ? fcd_pkg::FL_EQ :
             (ka < kb ? fcd_pkg::FL_LT : fcd_pkg::FL_GT);
   endfunction
   // ****************
   // checking and driving
   // ****************
   task automatic check(input logic [95:0] got, input logic [95:0] exp,
                        input string m);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t %s", $time, m);
      end
   endtask
   task automatic results;
      $display("fails %0d checks %0d", n_fail, check_count);
      if (n_fail == 0 && check_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic go;
      u_core.issue(r, s, v);
      check(v, 1'h1, "no response");
      check(s.cls, cls_f(r.a, r.fmt),
            "class");
      if (r.op < fcd_pkg::OP_CMP)
         check(s.flags, r.flags, "flags changed");
   endtask

   // about four times the expected run
   initial begin
      #200000;
      n_fail++;
      results;
   end

   initial begin
      void'($urandom(47));
      rst_i       = 1'h1;
      n_fail      = 0;
      check_count = 0;
      repeat (8) @(posedge clk_sys_i);
      @(negedge clk_sys_i);
      rst_i = 1'h0;
      check(rsp_valid_o, 1'h0, "valid after reset");
      check(rsp_o, '0, "response after reset");
      r = '0;
      // ****************
      // classify and widen
      // ****************
      for (k = 0; k < 311; k++) begin
         x = k < 11 ? tbl[k] : $urandom;
         if (k > 10 && $urandom % 4 == 0)
            x[30:23] = 8'h0;
         r.fmt   = fcd_pkg::FMT_SGL;
         r.a     = {$urandom, x};
         r.flags = 3'($urandom);
         r.op    = fcd_pkg::OP_CLASSIFY;
         go;
         check(s.result[63:0], r.a, "classify data");
         check(s.evt, 3'h0, "classify event");
         c = cl(x) == fcd_pkg::CLS_DEN;
         for (e = 0; e < 2; e++) begin
            r.op       = fcd_pkg::OP_TO_EXT;
            r.den_mask = e[0];
            go;
            check(s.evt.denormal, c, "denormal source");
            check(s.wr, !c || e[0], "widen write");
            if (s.wr === 1'h1)
               check(s.result, to_ext(x),
                     "widened");
         end
         r.a   = {$urandom, $urandom};
         if ($urandom % 2 == 0)
            r.a[62:52] = 11'h0;
         r.fmt = fcd_pkg::FMT_DBL;
         r.op  = fcd_pkg::OP_CLASSIFY;
         go;
         r.op       = fcd_pkg::OP_TO_EXT;
         r.den_mask = 1'h1;
         go;
         c = cls_f(r.a, 1'h1) == fcd_pkg::CLS_DEN;
         check(s.evt.denormal, c, "double denormal");
         if (c)
            check(s.result, dext(r.a), "double widened");
      end
      // ****************
      // pack to single
      // ****************
      r.op = fcd_pkg::OP_PACK_SGL;
      for (k = 0; k < 217; k++) begin
         e  = k < 16 ? 0 : (k < 24 ? pe[k - 16] : int'($urandom % 260) - 130);
         sg = k < 16 ? 64'h0 : (k < 24 ? ps[k - 16] : {$urandom, 32'h0});
         if (k > 23)
            sg[62] = 1'h1;
         r.tr_sign   = k < 16 ? k[0] : 1'($urandom);
         r.tr_cancel = k < 16 ? k[1] : 1'($urandom);
         r.rc        = fcd_pkg::fcd_rc_type'(2'(k < 16 ? k / 4 : $urandom));
         r.tr_exp    = 16'(e);
         r.tr_sig    = sg;
         ex = pack(r.tr_sign, e, sg, r.tr_cancel, r.rc);
         go;
         check(s.result[31:0], ex[31:0],
               "packed");
         check(s.evt.underflow, ex[32], "underflow");
      end
      // ****************
      // conditional move
      // ****************
      r.op = fcd_pkg::OP_CMOV;
      for (k = 0; k < 64; k++) begin
         r.cc     = fcd_pkg::fcd_cc_type'(k[1:0]);
         r.cc_neg = k[2];
         r.flags  = k[5:3];
         r.b      = {$urandom, $urandom};
         case (k[1:0])
            0: c = r.flags.cf;
            1: c = r.flags.zf;
            2: c = r.flags.cf | r.flags.zf;
            default: c = r.flags.pf;
         endcase
         c = c ^ k[2];
         go;
         check(s.wr, c, "move write");
         check(s.result[63:0], c ? r.b : r.a, "move data");
      end
      // ****************
      // compare into flags
      // ****************
      r.fmt = fcd_pkg::FMT_SGL;
      for (k = 0; k < 150; k++) begin
         x = k < 21 ? ca[k / 3] : $urandom;
         y = k < 21 ? cb[k / 3] : $urandom;
         if (k > 20 && k % 5 == 0)
            x[30:22] = {8'hff, 1'($urandom)};
         r.a     = {32'h0, x};
         r.b     = {32'h0, y};
         r.op    = k % 3 == 0 ? fcd_pkg::OP_CMP :
                   (k % 3 == 1 ? fcd_pkg::OP_CMP_POP : fcd_pkg::OP_UCMP_POP);
         r.flags = 3'($urandom);
         go;
         check(s.flags, cmp(x, y), "compare flags");
         check(s.pop, r.op != fcd_pkg::OP_CMP, "pop");
         c = r.op == fcd_pkg::OP_UCMP_POP ?
             (cl(x) == fcd_pkg::CLS_SNAN || cl(y) == fcd_pkg::CLS_SNAN) :
             (cl(x) >= fcd_pkg::CLS_QNAN || cl(y) >= fcd_pkg::CLS_QNAN);
         check(s.evt.invalid, c, "invalid");
         if (cmp(x, y) != fcd_pkg::FL_UNORD)
            check(s.evt.denormal, cl(x) == fcd_pkg::CLS_DEN ||
                  cl(y) == fcd_pkg::CLS_DEN, "denormal compare");
      end
      results;
   end
endmodule
